//--- dv/asram_host_test.sv
// Self-checking bench for the async SRAM host sequencer
module asram_host_test
  import asram_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PCYC = 8;
  logic i_ref_clk = 1'b0, i_rst_n = 1'b0, i_clk_en = 1'b1, i_req = 1'b0, i_we = 1'b0;
  logic [ADDR_W-1:0] i_addr = 20'h00000, o_mem_addr;
  logic [DATA_W-1:0] i_wdata = 16'h0000, o_rdata, o_mem_data, dq;
  logic [1:0]        i_lane_en = 2'b11;
  logic o_busy, o_ready, o_rd_valid, o_output_drive_enable_n, o_write_strobe_n, o_mem_data_oe;
  logic o_chip_select_low_active_n, o_chip_select_high_active;
  logic o_lower_byte_lane_select_n, o_upper_byte_lane_select_n;
  wire [DATA_W-1:0] i_mem_data = o_mem_data_oe ? o_mem_data : dq;
  int bad_count = 0, tests_run = 0, cycles = 0;
  asram_host #(.POWER_CYC(PCYC)) asram_host_inst (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_clk_en(i_clk_en), .i_req(i_req), .i_we(i_we), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_lane_en(i_lane_en), .o_busy(o_busy), .o_ready(o_ready), .o_rd_valid(o_rd_valid),
    .o_rdata(o_rdata), .o_mem_addr(o_mem_addr),
    .o_chip_select_low_active_n(o_chip_select_low_active_n),
    .o_chip_select_high_active(o_chip_select_high_active),
    .o_output_drive_enable_n(o_output_drive_enable_n), .o_write_strobe_n(o_write_strobe_n),
    .o_lower_byte_lane_select_n(o_lower_byte_lane_select_n),
    .o_upper_byte_lane_select_n(o_upper_byte_lane_select_n), .i_mem_data(i_mem_data),
    .o_mem_data(o_mem_data), .o_mem_data_oe(o_mem_data_oe));
  asram_sram_model asram_sram_model_inst (.i_addr(o_mem_addr),
    .i_sel_lo_n(o_chip_select_low_active_n), .i_sel_hi(o_chip_select_high_active),
    .i_oe_n(o_output_drive_enable_n), .i_we_n(o_write_strobe_n), .i_din(o_mem_data),
    .i_lane_n({o_upper_byte_lane_select_n, o_lower_byte_lane_select_n}), .o_dq(dq));
  initial forever #50 i_ref_clk = ~i_ref_clk;
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    if (bad_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Busy is high through the power wait, so idle is awaited before the request rises
  task automatic access(input logic w, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, input logic [1:0] l);
    int n;
    for (n = 0; n < 20 && o_busy !== 1'b0; n++) @(posedge i_ref_clk) #1;
    {i_we, i_addr, i_wdata, i_lane_en, i_req} = {w, a, d, l, 1'b1};
    for (n = 0; n < 20 && o_busy !== 1'b1; n++) @(posedge i_ref_clk) #1;
    i_req = 1'b0;
    for (n = 0; n < 20 && o_busy !== 1'b0; n++) @(posedge i_ref_clk) #1;
    check({15'h0000, o_busy}, 16'h0000);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [1:0] l, input logic [DATA_W-1:0] e);
    access(1'b0, a, 16'h0000, l);
    check({15'h0000, o_rd_valid}, 16'h0001);
    check(o_rdata, e);
  endtask
  task automatic do_reset();
    i_rst_n = 1'b0;
    repeat (10) @(posedge i_ref_clk);
    #1 i_rst_n = 1'b1;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_power();
    i_req = 1'b1;
    repeat (PCYC - 1) @(posedge i_ref_clk);
    #1 check({15'h0000, o_ready}, 16'h0000);
    @(posedge i_ref_clk) #1 i_req = 1'b0;
    check({15'h0000, o_ready}, 16'h0001);
  endtask
  task automatic t_full();
    access(1'b1, 20'hfffff, 16'ha5c3, 2'b11);
    access(1'b1, 20'h00000, 16'h3c5a, 2'b11);
    rd(20'hfffff, 2'b11, 16'ha5c3);
    rd(20'h00000, 2'b11, 16'h3c5a);
  endtask
  task automatic t_lanes();
    access(1'b1, 20'h12345, 16'h1122, 2'b11);
    access(1'b1, 20'h12345, 16'hee33, 2'b01);
    access(1'b1, 20'h12345, 16'h44ff, 2'b10);
    rd(20'h12345, 2'b11, 16'h4433);
    rd(20'h12345, 2'b01, 16'h0033);
    rd(20'h12345, 2'b10, 16'h4400);
    access(1'b1, 20'h12345, 16'h5566, 2'b00);
    rd(20'h12345, 2'b00, 16'h5566);
  endtask
  // Frozen clock enable must swallow a pending write
  task automatic t_freeze();
    i_clk_en = 1'b0;
    {i_we, i_addr, i_wdata, i_req} = {1'b1, 20'h00000, 16'hffff, 1'b1};
    repeat (5) @(posedge i_ref_clk);
    #1 check({15'h0000, o_chip_select_low_active_n}, 16'h0001);
    i_req = 1'b0;
    i_clk_en = 1'b1;
    @(posedge i_ref_clk) #1;
    rd(20'h00000, 2'b11, 16'h3c5a);
  endtask
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      $display("[FAIL] t=%0t timeout cycles=%h limit=%h", $time, cycles, 3000);
      stop_test();
    end
  end
  initial begin
    do_reset();
    t_power();
    t_full();
    t_lanes();
    t_freeze();
    do_reset();
    t_power();
    rd(20'hfffff, 2'b11, 16'ha5c3);
    stop_test();
  end
endmodule // asram_host_test

//--- dv/asram_properties.sv
// Checker of the host strobe sequencing
module asram_properties
  import asram_pkg::*;
#(
  parameter int POWER_CYC = POWER_WAIT_CYC
) (
  input wire logic              i_ref_clk,
  input wire logic              i_rst_n,
  input wire logic              i_clk_en,
  input wire logic              o_busy,
  input wire logic              o_ready,
  input wire logic              o_rd_valid,
  input wire logic [ADDR_W-1:0] o_mem_addr,
  input wire logic              o_chip_select_low_active_n,
  input wire logic              o_chip_select_high_active,
  input wire logic              o_output_drive_enable_n,
  input wire logic              o_write_strobe_n,
  input wire logic              o_lower_byte_lane_select_n,
  input wire logic              o_upper_byte_lane_select_n,
  input wire logic [DATA_W-1:0] o_mem_data,
  input wire logic              o_mem_data_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt_ff;
  wire cs = !o_chip_select_low_active_n;
  wire we = !o_write_strobe_n;
  wire oe = !o_output_drive_enable_n;
  wire [1:0] ln_n = {o_upper_byte_lane_select_n, o_lower_byte_lane_select_n};
  // Counts enabled cycles since reset, saturating
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_ff <= 0;
    end else if (i_clk_en && cnt_ff < POWER_CYC) begin
      cnt_ff <= cnt_ff + 1;
    end
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  sel_pair_a:
    assert property (o_chip_select_high_active == cs) else $error("select pair split");
  wait_power_a:
    assert property ((cs || o_ready) |-> cnt_ff >= POWER_CYC) else $error("early access");
  wr_start_a:
    assert property (we |-> cs && ln_n != 2'b11 && o_mem_data_oe) else $error("bad write");
  wr_pulse_a:
    assert property ($fell(o_write_strobe_n) |=> !we && cs && o_mem_data_oe
      && $stable(o_mem_data)) else $error("write pulse wrong");
  rd_release_a:
    assert property (oe |-> !o_mem_data_oe && !we) else $error("bus contention");
  addr_hold_a:
    assert property (cs |-> $stable(o_mem_addr) && $stable(ln_n)) else $error("addr moved");
  rd_timing_a:
    assert property ($fell(o_output_drive_enable_n) |-> cs ##4 $rose(o_output_drive_enable_n)
      && o_rd_valid && !o_busy) else $error("read timing");
  end_float_a:
    assert property ($rose(o_chip_select_low_active_n) |-> $past(o_write_strobe_n))
      else $error("strobe with deselect");
  idle_quiet_a:
    assert property (!o_busy |-> !cs && !o_mem_data_oe) else $error("idle not quiet");
  wr_c: cover property ($fell(o_write_strobe_n));
  rd_c: cover property (o_rd_valid);
  lane_c: cover property (we && ^ln_n);
endmodule // asram_properties

bind asram_host asram_properties #(.POWER_CYC(POWER_CYC)) asram_properties_inst (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en), .o_busy(o_busy),
  .o_ready(o_ready), .o_rd_valid(o_rd_valid), .o_mem_addr(o_mem_addr),
  .o_chip_select_low_active_n(o_chip_select_low_active_n),
  .o_chip_select_high_active(o_chip_select_high_active),
  .o_output_drive_enable_n(o_output_drive_enable_n), .o_write_strobe_n(o_write_strobe_n),
  .o_lower_byte_lane_select_n(o_lower_byte_lane_select_n),
  .o_upper_byte_lane_select_n(o_upper_byte_lane_select_n), .o_mem_data(o_mem_data),
  .o_mem_data_oe(o_mem_data_oe));

//--- dv/asram_sram_model.sv
// Behavioural model of the 1M x 16 asynchronous static memory
module asram_sram_model
  import asram_pkg::*;
(
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic              i_sel_lo_n,
  input  wire logic              i_sel_hi,
  input  wire logic              i_oe_n,
  input  wire logic              i_we_n,
  input  wire logic [LANES-1:0]  i_lane_n,
  input  wire logic [DATA_W-1:0] i_din,
  output logic      [DATA_W-1:0] o_dq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [DATA_W-1:0] word;
  wire sel = !i_sel_lo_n && i_sel_hi;
  // ----------------------------------------------------------------
  // Store and drive
  // ----------------------------------------------------------------
  // level write in window
  // lane drive; a float shows the inverse, never the last value
  // Explicit list: the array is written here and must not retrigger the block
  always @(i_addr or i_sel_lo_n or i_sel_hi or i_oe_n or i_we_n or i_lane_n or i_din) begin
    if (sel && !i_we_n) begin
      word = mem.exists(i_addr) ? mem[i_addr] : 16'h0000;
      if (!i_lane_n[0]) word[7:0] = i_din[7:0];
      if (!i_lane_n[1]) word[15:8] = i_din[15:8];
      mem[i_addr] = word;
    end
    word = mem.exists(i_addr) ? mem[i_addr] : 16'h0000;
    for (int b = 0; b < LANES; b++) begin
      o_dq[b*8 +: 8] = (sel && !i_oe_n && i_we_n && !i_lane_n[b]) ?
                       word[b*8 +: 8] : ~word[b*8 +: 8];
    end
  end
endmodule // asram_sram_model

//--- include/asram_pkg.sv
// Package of constants for the async SRAM host controller
package asram_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int LANES  = 2;

  // ----------------------------------------------------------------
  // Timing in ns, rounded up to whole clock cycles
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 100;
  localparam int POWER_WAIT_NS   = 1000000;
  localparam int POWER_WAIT_CYC  = (POWER_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_FLOAT_NS     = 6;
  localparam int WR_SETUP_NS     = 6;
  localparam int WR_PULSE_NS     = 8;
  localparam int WR_PULSE_RAW    =
    (WR_FLOAT_NS + WR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_PULSE_CYC    = (WR_PULSE_RAW < 1) ? 1 : WR_PULSE_RAW;
  localparam int RD_ACCESS_NS    = 12;
  localparam int RD_ACCESS_RAW   = (RD_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_ACCESS_CYC   = (RD_ACCESS_RAW < 1) ? 1 : RD_ACCESS_RAW;
  localparam int CNT_W           = 14;
  localparam int WAIT_W          = 4;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_POWER,
    ST_IDLE,
    ST_WR_SETUP,
    ST_WR_PULSE,
    ST_WR_END,
    ST_RD_SETUP,
    ST_RD_WAIT,
    ST_RD_END
  } asram_state_t;

endpackage

//--- rtl/asram_host.sv
// Host-side sequencer driving an asynchronous 1M x 16 static memory
// Behaviour
// - A write with the chip selected and write strobe low stores the low byte if its lane is low.
// - A write stores the high byte if its lane select is low, leaving a high-select lane unchanged.
// - A read needs selection, output enable low and write strobe high; low lane drives low byte.
// - A write starts only with both selects active, strobe low and at least one lane low.
// - Write data setup and hold are timed from the edge of the signal that ends the write.
// - The host waits the power-on time before its first read or write.
// - A strobe-controlled write with output enable low lasts float delay plus data setup.
// - For a read the address is valid no later than the chip selects go active.
module asram_host
  import asram_pkg::*;
#(
  parameter int POWER_CYC = POWER_WAIT_CYC
) (
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_clk_en,
  input  wire logic              i_req,
  input  wire logic              i_we,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic [LANES-1:0]  i_lane_en,
  output logic                   o_busy,
  output logic                   o_ready,
  output logic                   o_rd_valid,
  output logic [DATA_W-1:0]      o_rdata,
  output logic [ADDR_W-1:0]      o_mem_addr,
  output logic                   o_chip_select_low_active_n,
  output logic                   o_chip_select_high_active,
  output logic                   o_output_drive_enable_n,
  output logic                   o_write_strobe_n,
  output logic                   o_lower_byte_lane_select_n,
  output logic                   o_upper_byte_lane_select_n,
  input  wire logic [DATA_W-1:0] i_mem_data,
  output logic [DATA_W-1:0]      o_mem_data,
  output logic                   o_mem_data_oe
);

  asram_state_t      state_ff;
  logic [WAIT_W-1:0] wait_ff;
  logic              pwr_ready;
  logic              busy_ff;
  logic              rd_valid_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic              cs_ff;
  logic              cs_n_ff;
  logic              nxt_cs;
  logic              oe_n_ff;
  logic              we_n_ff;
  logic [LANES-1:0]  lane_n_ff;
  logic [DATA_W-1:0] dout_ff;
  logic              doe_ff;
  logic [DATA_W-1:0] din_meta_ff;
  logic [DATA_W-1:0] din_sync_ff;
  logic [LANES-1:0]  lane_req;

  // ----------------------------------------------------------------
  // Power-on wait
  // ----------------------------------------------------------------
  asram_pwr_wait #(
    .WAIT_CYC (POWER_CYC)
  ) u_pwr (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_ce      (i_clk_en),
    .o_ready   (pwr_ready)
  );

  // No lane asked means both lanes, so a write always has a lane low
  assign lane_req = (i_lane_en == '0) ? '1 : i_lane_en;

  // Two select flops, so neither select pin passes an inverter after its register
  assign nxt_cs = (state_ff == ST_WR_SETUP) || (state_ff == ST_WR_PULSE) ||
                  (state_ff == ST_RD_SETUP) || (state_ff == ST_RD_WAIT);

  // ----------------------------------------------------------------
  // Read data synchroniser
  // ----------------------------------------------------------------
  // Pins are asynchronous to us, so two stages before capture
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      din_meta_ff <= '0;
      din_sync_ff <= '0;
    end else if (i_clk_en) begin
      din_meta_ff <= i_mem_data;
      din_sync_ff <= din_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= ST_POWER;
      wait_ff  <= '0;
    end else if (i_clk_en) begin
      unique case (state_ff)
        ST_POWER: begin
          if (pwr_ready) begin
            state_ff <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (i_req) begin
            state_ff <= i_we ? ST_WR_SETUP : ST_RD_SETUP;
          end
        end
        ST_WR_SETUP: begin
          state_ff <= ST_WR_PULSE;
          wait_ff  <= WAIT_W'(WR_PULSE_CYC - 1);
        end
        ST_WR_PULSE: begin
          if (wait_ff == '0) begin
            state_ff <= ST_WR_END;
          end else begin
            wait_ff <= wait_ff - 1'b1;
          end
        end
        ST_WR_END: begin
          state_ff <= ST_IDLE;
        end
        ST_RD_SETUP: begin
          state_ff <= ST_RD_WAIT;
          wait_ff  <= WAIT_W'(RD_ACCESS_CYC + 1);
        end
        // Covers access time plus the two synchroniser stages
        ST_RD_WAIT: begin
          if (wait_ff == '0) begin
            state_ff <= ST_RD_END;
          end else begin
            wait_ff <= wait_ff - 1'b1;
          end
        end
        ST_RD_END: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Address and lanes
  // ----------------------------------------------------------------
  // latched stable per access
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      addr_ff   <= '0;
      lane_n_ff <= '1;
      dout_ff   <= '0;
    end else if (i_clk_en && state_ff == ST_IDLE && i_req) begin
      addr_ff   <= i_addr;
      lane_n_ff <= ~lane_req;
      dout_ff   <= i_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Strobes
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cs_ff   <= 1'b0;
      cs_n_ff <= 1'b1;
      oe_n_ff <= 1'b1;
      we_n_ff <= 1'b1;
      doe_ff  <= 1'b0;
    end else if (i_clk_en) begin
      cs_ff   <= nxt_cs;
      cs_n_ff <= !nxt_cs;
      we_n_ff <= !(state_ff == ST_WR_SETUP ||
                   (state_ff == ST_WR_PULSE && wait_ff != '0));
      doe_ff  <= (state_ff == ST_IDLE && i_req && i_we) ||
                 (doe_ff && state_ff != ST_WR_END);
      oe_n_ff <= !(state_ff == ST_RD_SETUP || state_ff == ST_RD_WAIT) || doe_ff;
    end
  end

  // ----------------------------------------------------------------
  // Read capture and status
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_ff    <= '0;
      rd_valid_ff <= 1'b0;
      busy_ff     <= 1'b1;
    end else if (i_clk_en) begin
      rd_valid_ff <= (state_ff == ST_RD_END);
      if (state_ff == ST_RD_END) begin
        rdata_ff <= din_sync_ff & {{BYTE_W{~lane_n_ff[1]}}, {BYTE_W{~lane_n_ff[0]}}};
      end
      busy_ff <= !(state_ff == ST_IDLE && !i_req) &&
                 !(state_ff == ST_POWER && pwr_ready) &&
                 !(state_ff == ST_WR_END) && !(state_ff == ST_RD_END);
    end
  end

  assign o_busy                     = busy_ff;
  assign o_ready                    = pwr_ready;
  assign o_rd_valid                 = rd_valid_ff;
  assign o_rdata                    = rdata_ff;
  assign o_mem_addr                 = addr_ff;
  assign o_chip_select_low_active_n = cs_n_ff;
  assign o_chip_select_high_active  = cs_ff;
  assign o_output_drive_enable_n    = oe_n_ff;
  assign o_write_strobe_n           = we_n_ff;
  assign o_lower_byte_lane_select_n = lane_n_ff[0];
  assign o_upper_byte_lane_select_n = lane_n_ff[1];
  assign o_mem_data                 = dout_ff;
  assign o_mem_data_oe              = doe_ff;

endmodule // asram_host

//--- rtl/asram_pwr_wait.sv
// Power-on wait counter holding off the first access
module asram_pwr_wait
  import asram_pkg::*;
#(
  parameter int WAIT_CYC = POWER_WAIT_CYC
) (
  input  wire logic i_ref_clk,
  input  wire logic i_rst_n,
  input  wire logic i_ce,
  output logic      o_ready
);

  logic [CNT_W-1:0] cnt_ff;
  logic             ready_ff;

  // ----------------------------------------------------------------
  // Count
  // ----------------------------------------------------------------
  // power-on hold
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_ff   <= '0;
      ready_ff <= 1'b0;
    end else if (i_ce && !ready_ff) begin
      if (cnt_ff == CNT_W'(WAIT_CYC - 1)) begin
        ready_ff <= 1'b1;
      end else begin
        cnt_ff <= cnt_ff + 1'b1;
      end
    end
  end

  assign o_ready = ready_ff;

endmodule // asram_pwr_wait
